// ===== rtl/bst_pkg.sv
// Constants and types shared by the boundary-scan test port.
package bst_pkg;

  // ==========================================================
  // Register widths and codes
  localparam int          IR_W       = 4;
  localparam int          ID_W       = 32;
  localparam int          CFG_W      = 8;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  localparam logic [3:0]  IR_IDCODE  = 4'h2;
  localparam logic [3:0]  IR_BYPASS  = 4'hF;
  // Arbitrary identification value; bit 0 must stay set.
  localparam logic [31:0] ID_VALUE   = 32'h0A5C_0001;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [2:0]  TMS_RESET_CYCLES = 3'h5;

  // ==========================================================
  // Controller states
  typedef enum logic [3:0] {
    S_TLR  = 4'b0000,
    S_RTI  = 4'b0001,
    S_SDRS = 4'b0010,
    S_CDR  = 4'b0011,
    S_SDR  = 4'b0100,
    S_E1DR = 4'b0101,
    S_PDR  = 4'b0110,
    S_E2DR = 4'b0111,
    S_UDR  = 4'b1000,
    S_SIRS = 4'b1001,
    S_CIR  = 4'b1010,
    S_SIR  = 4'b1011,
    S_E1IR = 4'b1100,
    S_PIR  = 4'b1101,
    S_E2IR = 4'b1110,
    S_UIR  = 4'b1111
  } bst_state_t;

endpackage

// ===== rtl/bst_tap.sv
// Boundary-scan test access port sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none

module bst_tap
  import bst_pkg::*;
(
  input  wire logic             CORE_CLK,           // Core clock, 100 MHz.
  input  wire logic             RST,                // Synchronous reset, active high.
  input  wire logic             TCK,                // Test clock pin.
  input  wire logic             TMS,                // Test mode select pin.
  input  wire logic             TDI,                // Test data in pin.
  input  wire logic             TRST_N,             // Test reset pin, active low.
  input  wire logic             FIFO_MASTER_INIT_N, // FIFO master reset pin.
  input  wire logic [CFG_W-1:0] CFG_PINS,           // Configuration pins.
  output logic                  TDO,                // Test data out.
  output logic                  TDO_OE,             // Test data out enable.
  output logic                  Q_DRIVE_OK,         // FIFO data outputs may drive.
  output logic                  PTR_CLEAR,          // Clear pointers and output register.
  output logic      [CFG_W-1:0] CFG_LATCHED         // Configuration caught at init.
);

  // ==========================================================
  // Pin synchronisers
  logic             tck_s1_reg;
  logic             tck_s2_reg;
  logic             tck_s3_reg;
  logic             tms_s1_reg;
  logic             tms_s2_reg;
  logic             tdi_s1_reg;
  logic             tdi_s2_reg;
  logic             trst_s1_reg;
  logic             trst_s2_reg;
  logic             mri_s1_reg;
  logic             mri_s2_reg;
  logic [CFG_W-1:0] cfg_s1_reg;
  logic [CFG_W-1:0] cfg_s2_reg;

  // The test clock is sampled, so it must stay well below half the core rate.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tck_s1_reg  <= 1'b0;
      tck_s2_reg  <= 1'b0;
      tck_s3_reg  <= 1'b0;
      tms_s1_reg  <= 1'b1;
      tms_s2_reg  <= 1'b1;
      tdi_s1_reg  <= 1'b1;
      tdi_s2_reg  <= 1'b1;
      trst_s1_reg <= 1'b1;
      trst_s2_reg <= 1'b1;
      mri_s1_reg  <= 1'b1;
      mri_s2_reg  <= 1'b1;
      cfg_s1_reg  <= CFG_RST;
      cfg_s2_reg  <= CFG_RST;
    end else begin
      tck_s1_reg  <= TCK;
      tck_s2_reg  <= tck_s1_reg;
      tck_s3_reg  <= tck_s2_reg;
      tms_s1_reg  <= TMS;
      tms_s2_reg  <= tms_s1_reg;
      tdi_s1_reg  <= TDI;
      tdi_s2_reg  <= tdi_s1_reg;
      trst_s1_reg <= TRST_N;
      trst_s2_reg <= trst_s1_reg;
      mri_s1_reg  <= FIFO_MASTER_INIT_N;
      mri_s2_reg  <= mri_s1_reg;
      cfg_s1_reg  <= CFG_PINS;
      cfg_s2_reg  <= cfg_s1_reg;
    end
  end

  logic tck_rise;
  logic tck_fall;

  // Edges of the sampled test clock pace all test work except the test reset from TRST_N, which forces S_TLR on any core cycle.
  assign tck_rise = tck_s2_reg & ~tck_s3_reg;
  assign tck_fall = ~tck_s2_reg & tck_s3_reg;

  // ==========================================================
  // Controller state machine
  function automatic bst_state_t tap_next(input bst_state_t s, input logic m);
    case (s)
      S_TLR:   tap_next = m ? S_TLR  : S_RTI;
      S_RTI:   tap_next = m ? S_SDRS : S_RTI;
      S_SDRS:  tap_next = m ? S_SIRS : S_CDR;
      S_CDR:   tap_next = m ? S_E1DR : S_SDR;
      S_SDR:   tap_next = m ? S_E1DR : S_SDR;
      S_E1DR:  tap_next = m ? S_UDR  : S_PDR;
      S_PDR:   tap_next = m ? S_E2DR : S_PDR;
      S_E2DR:  tap_next = m ? S_UDR  : S_SDR;
      S_UDR:   tap_next = m ? S_SDRS : S_RTI;
      S_SIRS:  tap_next = m ? S_TLR  : S_CIR;
      S_CIR:   tap_next = m ? S_E1IR : S_SIR;
      S_SIR:   tap_next = m ? S_E1IR : S_SIR;
      S_E1IR:  tap_next = m ? S_UIR  : S_PIR;
      S_PIR:   tap_next = m ? S_E2IR : S_PIR;
      S_E2IR:  tap_next = m ? S_UIR  : S_SIR;
      S_UIR:   tap_next = m ? S_SDRS : S_RTI;
      default: tap_next = S_TLR;
    endcase
  endfunction

  bst_state_t state_reg;

  // Core reset leaves the controller idle rather than reset, so the FIFO
  // outputs stay off until the tester resets the port itself.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_reg <= S_RTI;
    end else if (!trst_s2_reg) begin
      state_reg <= S_TLR;
    end else if (tck_rise) begin
      state_reg <= tap_next(state_reg, tms_s2_reg);
    end
  end

  // ==========================================================
  // Instruction and data registers
  logic [IR_W-1:0] ir_reg;
  logic [IR_W-1:0] ir_sh_reg;
  logic [ID_W-1:0] id_sh_reg;
  logic            byp_reg;
  logic            sel_id;

  assign sel_id = (ir_reg == IR_IDCODE);

  always_ff @(posedge CORE_CLK) begin
    if (RST || state_reg == S_TLR) begin
      ir_reg <= IR_IDCODE;
    end else if (tck_rise && state_reg == S_UIR) begin
      ir_reg <= ir_sh_reg;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ir_sh_reg <= IR_CAPTURE;
    end else if (tck_rise && state_reg == S_CIR) begin
      ir_sh_reg <= IR_CAPTURE;
    end else if (tck_rise && state_reg == S_SIR) begin
      ir_sh_reg <= {tdi_s2_reg, ir_sh_reg[IR_W-1:1]};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      id_sh_reg <= ID_VALUE;
      byp_reg   <= 1'b0;
    end else if (tck_rise && state_reg == S_CDR) begin
      id_sh_reg <= ID_VALUE;
      byp_reg   <= 1'b0;
    end else if (tck_rise && state_reg == S_SDR) begin
      if (sel_id) begin
        id_sh_reg <= {tdi_s2_reg, id_sh_reg[ID_W-1:1]};
      end else begin
        byp_reg <= tdi_s2_reg;
      end
    end
  end

  // ==========================================================
  // Test data out
  logic in_shift;
  logic sh_bit;

  assign in_shift = (state_reg == S_SDR) || (state_reg == S_SIR);
  assign sh_bit   = (state_reg == S_SIR) ? ir_sh_reg[0] :
                    (sel_id ? id_sh_reg[0] : byp_reg);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO    <= sh_bit;
      TDO_OE <= in_shift;
    end
  end

  // ==========================================================
  // FIFO side effects
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      Q_DRIVE_OK <= 1'b0;
    end else if (state_reg == S_TLR) begin
      Q_DRIVE_OK <= 1'b1;
    end
  end

  // A test reset tied to master reset enables the outputs through S_TLR; this path only clears pointers and latches configuration.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PTR_CLEAR   <= 1'b0;
      CFG_LATCHED <= CFG_RST;
    end else begin
      PTR_CLEAR <= ~mri_s2_reg;
      if (!mri_s2_reg) begin
        CFG_LATCHED <= cfg_s2_reg;
      end
    end
  end

  // ==========================================================
  // Checks
  logic [2:0] tms_hi_cnt_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST || !trst_s2_reg) begin
      tms_hi_cnt_reg <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s2_reg) begin
        tms_hi_cnt_reg <= 3'h0;
      end else if (tms_hi_cnt_reg != TMS_RESET_CYCLES) begin
        tms_hi_cnt_reg <= tms_hi_cnt_reg + 3'h1;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  chk_tdo_oe_shift: assert property (
    tck_fall |=> (TDO_OE == $past(in_shift)))
    else $error("TDO enable does not follow the shift state.");

  chk_tdo_fall_only: assert property (
    !tck_fall |=> ($stable(TDO) && $stable(TDO_OE)))
    else $error("TDO changed away from a falling test clock.");

  chk_tdo_value: assert property (
    (tck_fall && in_shift) |=> (TDO == $past(sh_bit)))
    else $error("TDO does not carry the selected register bit.");

  chk_trst_reset: assert property (
    !trst_s2_reg |=> (state_reg == S_TLR))
    else $error("Test reset did not force the reset state.");

  chk_tms_walk: assert property (
    (tck_rise && trst_s2_reg && state_reg == S_TLR && !tms_s2_reg)
      |=> (state_reg == S_RTI))
    else $error("Low mode select did not leave the reset state.");

  chk_state_hold: assert property (
    (!tck_rise && trst_s2_reg) |=> $stable(state_reg))
    else $error("State moved without a rising test clock.");

  chk_five_highs: assert property (
    (tms_hi_cnt_reg == TMS_RESET_CYCLES) |-> (state_reg == S_TLR))
    else $error("Five high mode cycles did not reach reset.");

  chk_q_gate: assert property (
    (!Q_DRIVE_OK && state_reg != S_TLR) |=> !Q_DRIVE_OK)
    else $error("FIFO outputs enabled before a controller reset.");

  chk_ir_capture: assert property (
    (tck_rise && trst_s2_reg && state_reg == S_CIR) |=> (ir_sh_reg == IR_CAPTURE))
    else $error("Instruction capture value wrong.");

  chk_bypass_shift: assert property (
    (tck_rise && trst_s2_reg && state_reg == S_SDR && !sel_id)
      |=> (byp_reg == $past(tdi_s2_reg)))
    else $error("Bypass bit did not take the sampled data.");

  chk_tlr_idcode: assert property (
    (state_reg == S_TLR) |=> (ir_reg == IR_IDCODE))
    else $error("Reset state did not select identification.");

  chk_init_clear: assert property (
    !mri_s2_reg |=> (PTR_CLEAR && CFG_LATCHED == $past(cfg_s2_reg)))
    else $error("Master init did not clear or latch configuration.");

  chk_ir_update: assert property (
    (tck_rise && trst_s2_reg && state_reg == S_UIR) |=> (ir_reg == $past(ir_sh_reg)))
    else $error("Update did not load the new instruction.");

  chk_id_capture: assert property (
    (tck_rise && trst_s2_reg && state_reg == S_CDR) |=> (id_sh_reg == ID_VALUE && !byp_reg))
    else $error("Data capture did not load the identification value.");

  chk_q_enable: assert property (
    (state_reg == S_TLR) |=> Q_DRIVE_OK)
    else $error("Reset state did not enable the FIFO outputs.");

endmodule

`default_nettype wire

// ===== bench/bst_ctl_model.sv
// Model of the outside test controller that clocks the scan port.
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
  input  wire logic core_clk, // Core clock that paces the test clock.
  input  wire logic tdo,      // Test data out from the port.
  input  wire logic tdo_oe,   // Test data out enable.
  output var  logic tck,      // Test clock, parked low between frames.
  output var  logic tms,      // Test mode select.
  output var  logic tdi,      // Test data in.
  output var  logic glitch    // Set when TDO moved while TCK was high.
);
  logic held;

  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b1;
    glitch = 1'b0;
  end

  // ==========================================================
  // One test clock period of 16 core cycles, returned low
  // Mode and data change 4 cycles before the rise and hold 12 after it,
  // which leaves room for the two-stage synchronisers.
  task automatic step(input logic m, input logic d, output logic so, output logic soe);
    @(posedge core_clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge core_clk);
    #1;
    // A released pin has no pull-up, so it shows the inverse of the last bit.
    so  = tdo_oe ? tdo : ~tdo;
    soe = tdo_oe;
    @(posedge core_clk);
    tck <= 1'b1;
    #1;
    held = tdo;
    repeat (7) @(posedge core_clk);
    #1;
    if (tdo !== held) glitch = 1'b1;
    @(posedge core_clk);
    tck <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== bench/boundary_scan_test_port_bench.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port_bench;
  import bst_pkg::*;
  logic             core_clk = 1'b0;
  logic             rst      = 1'b1;
  logic             trst_n   = 1'b1;
  logic             init_n   = 1'b1;
  logic [CFG_W-1:0] cfg_pins = 8'h00;
  wire logic        tck, tms, tdi, tdo, tdo_oe, q_ok, ptr_clear;
  wire logic [CFG_W-1:0] cfg_latched;
  wire logic        glitch_seen;
  logic             bit_o, oe_o;
  logic [31:0]      d;
  int               failures = 0;
  int               n_tests  = 0;

  always #5 core_clk = ~core_clk;

  bst_tap i_dut (
    .CORE_CLK(core_clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TRST_N(trst_n), .FIFO_MASTER_INIT_N(init_n), .CFG_PINS(cfg_pins),
    .TDO(tdo), .TDO_OE(tdo_oe), .Q_DRIVE_OK(q_ok), .PTR_CLEAR(ptr_clear),
    .CFG_LATCHED(cfg_latched)
  );
  bst_ctl_model i_ctl (
    .core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi), .glitch(glitch_seen)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Shifts n bits LSB first from a Shift state, then exits to Run-Test/Idle.
  task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      i_ctl.step(i == n - 1, din[i], bit_o, oe_o);
      dout[i] = bit_o;
      check(oe_o === 1'b1, "TDO not driven while shifting");
    end
    i_ctl.step(1'b1, 1'b1, bit_o, oe_o);
    check(oe_o === 1'b0, "TDO driven in exit state");
    i_ctl.step(1'b0, 1'b1, bit_o, oe_o);
  endtask

  task automatic ir_scan(input logic [3:0] din, output logic [31:0] dout);
    i_ctl.step(1'b1, 1'b1, bit_o, oe_o);
    i_ctl.step(1'b1, 1'b1, bit_o, oe_o);
    i_ctl.step(1'b0, 1'b1, bit_o, oe_o);
    i_ctl.step(1'b0, 1'b1, bit_o, oe_o);
    check(oe_o === 1'b0, "TDO driven in capture state");
    scan(IR_W, {28'h0000000, din}, dout);
  endtask

  task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    i_ctl.step(1'b1, 1'b1, bit_o, oe_o);
    i_ctl.step(1'b0, 1'b1, bit_o, oe_o);
    i_ctl.step(1'b0, 1'b1, bit_o, oe_o);
    scan(n, din, dout);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_power_up();
    for (int i = 0; i < 3; i++) i_ctl.step(1'b0, 1'b1, bit_o, oe_o);
    check(q_ok === 1'b0, "outputs enabled without controller reset");
    check(oe_o === 1'b0, "TDO driven in idle");
    for (int i = 0; i < 5; i++) i_ctl.step(1'b1, 1'b1, bit_o, oe_o);
    repeat (4) @(posedge core_clk);
    check(q_ok === 1'b1, "five mode-high clocks did not reset");
  endtask

  task automatic t_test_reset();
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(q_ok === 1'b0, "outputs enabled after core reset");
    trst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(q_ok === 1'b1, "test reset ignored without test clock");
    trst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    i_ctl.step(1'b0, 1'b1, bit_o, oe_o);
    dr_scan(ID_W, 32'h0000_0000, d);
    check(d === ID_VALUE, "default data register not identification");
  endtask

  task automatic t_instructions();
    ir_scan(IR_BYPASS, d);
    check(d[3:0] === IR_CAPTURE, "instruction capture value wrong");
    dr_scan(3, 32'h0000_0005, d);
    check(d[2:0] === 3'h2, "bypass path wrong");
    ir_scan(IR_IDCODE, d);
    dr_scan(ID_W, 32'hFFFF_FFFF, d);
    check(d === ID_VALUE, "identification read wrong");
  endtask

  task automatic t_master_init();
    init_n   <= 1'b0;
    cfg_pins <= 8'hA5;
    repeat (5) @(posedge core_clk);
    check(ptr_clear === 1'b1, "pointer clear missing");
    check(cfg_latched === 8'hA5, "configuration not latched");
    init_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    cfg_pins <= 8'h3C;
    repeat (6) @(posedge core_clk);
    check(ptr_clear === 1'b0, "pointer clear stuck");
    check(cfg_latched === 8'hA5, "configuration moved after init");
  endtask

  // Test reset tied to master reset, as a system without its own test reset does.
  task automatic t_tied_reset();
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(q_ok === 1'b0, "outputs enabled after second core reset");
    trst_n <= 1'b0;
    init_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(q_ok === 1'b1, "tied resets did not enable outputs");
    check(ptr_clear === 1'b1, "tied resets did not clear pointers");
    trst_n <= 1'b1;
    init_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(q_ok === 1'b1, "outputs lost after tied resets");
    check(ptr_clear === 1'b0, "pointer clear stuck after tied resets");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_power_up();
    t_test_reset();
    t_instructions();
    t_master_init();
    t_tied_reset();
    check(glitch_seen === 1'b0, "TDO changed while test clock high");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
